// ===== hdl/bbsc_pkg.sv
// Shared constants and types of the byte bus SRAM controller and its host
package bbsc_pkg;

   localparam int ADDR_W = 19;
   localparam int BYTE_W = 8;
   localparam int PROG_W = 4;

   // Command select codes, {cmd_select_high, cmd_select_low}
   localparam logic [1:0] CMD_WRITE    = 2'h0;
   localparam logic [1:0] CMD_READ     = 2'h1;
   localparam logic [1:0] CMD_LOAD_LOW = 2'h2;
   localparam logic [1:0] CMD_LOAD_MID = 2'h3;

   // Behaviour byte field positions
   localparam int PROG_READ_SIGN_BIT  = 3;
   localparam int PROG_READ_MAG_BIT   = 2;
   localparam int PROG_WRITE_SIGN_BIT = 1;
   localparam int PROG_WRITE_MAG_BIT  = 0;

   localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h0_0000;
   localparam logic [PROG_W-1:0] PROG_RESET = 4'h0;
   localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
   localparam logic [BYTE_W-1:0] BUS_IDLE   = 8'hFF;

   // Host strobe timing
   localparam int CORE_CLK_PERIOD_NS = 8;
   localparam int SETUP_NS           = 16;
   localparam int STROBE_HIGH_NS     = 48;
   localparam int STROBE_LOW_NS      = 24;
   localparam logic [3:0] SETUP_CYCLES =
      4'((SETUP_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS);
   localparam logic [3:0] HIGH_CYCLES =
      4'((STROBE_HIGH_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS);
   localparam logic [3:0] LOW_CYCLES =
      4'((STROBE_LOW_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS);

   // Host register map (APB byte addresses)
   localparam logic [11:0] REG_CMD_OFS    = 12'h000;
   localparam logic [11:0] REG_STATUS_OFS = 12'h004;
   localparam logic [11:0] REG_CTRL_OFS   = 12'h008;

   localparam int CMD_DATA_LSB         = 0;
   localparam int CMD_SEL_LSB          = 8;
   localparam int STATUS_BUSY_BIT      = 0;
   localparam int STATUS_CARD_RST_BIT  = 1;
   localparam int STATUS_RDATA_LSB     = 8;
   localparam int CTRL_CARD_RST_BIT    = 0;
   localparam logic CTRL_CARD_RST_RESET = 1'b1;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SETUP,
      ST_HIGH,
      ST_LOW
   } bbsc_state_type;

endpackage

// ===== hdl/bbsc_link_if.sv
// Link between host and byte bus SRAM controller
`timescale 1ns/1ps
interface bbsc_link_if;
   import bbsc_pkg::*;

   logic              strobe;
   logic              cmd_select_high;
   logic              cmd_select_low;
   logic              card_reset_n;
   logic [BYTE_W-1:0] host_bus_out;
   logic              host_bus_oe;
   logic [BYTE_W-1:0] dev_bus_out;
   logic              dev_bus_oe;
   logic [BYTE_W-1:0] shared_byte_bus;

   // Pulled up when nobody drives
   assign shared_byte_bus = host_bus_oe ? host_bus_out :
                            dev_bus_oe  ? dev_bus_out  : BUS_IDLE;

   modport host (
      output strobe,
      output cmd_select_high,
      output cmd_select_low,
      output card_reset_n,
      output host_bus_out,
      output host_bus_oe,
      input  shared_byte_bus
   );

   modport device (
      input  strobe,
      input  cmd_select_high,
      input  cmd_select_low,
      input  card_reset_n,
      output dev_bus_out,
      output dev_bus_oe,
      input  shared_byte_bus
   );

endinterface

// ===== hdl/bbsc_device.sv
// Byte bus SRAM controller, clocked by the host's command strobe
`timescale 1ns/1ps
module bbsc_device (
   bbsc_link_if.device                LINK,
   output logic [bbsc_pkg::ADDR_W-1:0] SRAM_ADDR,
   input  wire logic [bbsc_pkg::BYTE_W-1:0] SRAM_DQ_IN,
   output logic [bbsc_pkg::BYTE_W-1:0] SRAM_DQ_OUT,
   output logic                        SRAM_DQ_OE,
   output logic                        SRAM_CE_N,
   output logic                        SRAM_OE_N,
   output logic                        SRAM_WE_N,
   output logic [bbsc_pkg::PROG_W-1:0] PROGRAM_INDICATORS,
   output logic                        PROGRAM_MODE,
   output logic                        READ_LED,
   output logic                        WRITE_LED,
   output logic                        LATCH_LED
);
   import bbsc_pkg::*;

   logic [1:0]        cmd_reg;
   logic [BYTE_W-1:0] data_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [PROG_W-1:0] prog_reg;
   logic              prog_mode_reg;
   logic [1:0]        cmd_pins;
   logic              active;
   logic              is_read;
   logic              is_write;
   logic              is_load;

   // One step of the address counter, wrapping at both ends
   function automatic logic [ADDR_W-1:0] step_addr(
      input logic [ADDR_W-1:0] addr,
      input logic              sign,
      input logic              mag
   );
      logic [ADDR_W-1:0] res;
      res = addr;
      if (mag) begin
         if (sign) begin
            res = addr + 19'h0_0001;
         end else begin
            res = addr - 19'h0_0001;
         end
      end
      return res;
   endfunction

   assign cmd_pins = {LINK.cmd_select_high, LINK.cmd_select_low};

   // Rising edge: capture command and bus byte
   always_ff @(posedge LINK.strobe or negedge LINK.card_reset_n) begin
      if (!LINK.card_reset_n) begin
         cmd_reg  <= CMD_WRITE;
         data_reg <= BYTE_RESET;
      end else begin
         cmd_reg  <= cmd_pins;
         data_reg <= LINK.shared_byte_bus;
      end
   end

   // Falling edge: program byte taken once after reset
   always_ff @(negedge LINK.strobe or negedge LINK.card_reset_n) begin
      if (!LINK.card_reset_n) begin
         prog_mode_reg <= 1'b1;
         prog_reg      <= PROG_RESET;
      end else if (prog_mode_reg) begin
         prog_reg      <= data_reg[PROG_W-1:0];
         prog_mode_reg <= 1'b0;
      end
   end

   // Falling edge: address loads and post-access stepping.
   // Stepping on the trailing edge keeps the address steady
   // for the whole access while the strobe is high.
   always_ff @(negedge LINK.strobe or negedge LINK.card_reset_n) begin
      if (!LINK.card_reset_n) begin
         addr_reg <= ADDR_RESET;
      end else if (!prog_mode_reg) begin
         unique case (cmd_reg)
            CMD_LOAD_LOW: begin
               addr_reg[7:0] <= data_reg;
            end
            CMD_LOAD_MID: begin
               addr_reg <= {3'b000, data_reg, addr_reg[7:0]};
            end
            CMD_READ: begin
               addr_reg <= step_addr(addr_reg,
                                     prog_reg[PROG_READ_SIGN_BIT],
                                     prog_reg[PROG_READ_MAG_BIT]);
            end
            CMD_WRITE: begin
               addr_reg <= step_addr(addr_reg,
                                     prog_reg[PROG_WRITE_SIGN_BIT],
                                     prog_reg[PROG_WRITE_MAG_BIT]);
            end
         endcase
      end
   end

   // Decode from the pins, not cmd_reg: the pins are steady before
   // the strobe rises, cmd_reg would glitch with the old command.
   assign active   = LINK.strobe && LINK.card_reset_n && !prog_mode_reg;
   assign is_read  = active && (cmd_pins == CMD_READ);
   assign is_write = active && (cmd_pins == CMD_WRITE);
   assign is_load  = active && cmd_pins[1];

   // SRAM control; address may move as WE rises, the SRAM's
   // zero hold time on address is relied upon
   assign SRAM_ADDR   = addr_reg;
   assign SRAM_CE_N   = !(is_read || is_write);
   assign SRAM_OE_N   = !is_read;
   assign SRAM_WE_N   = !is_write;
   assign SRAM_DQ_OUT = data_reg;
   assign SRAM_DQ_OE  = is_write;

   // Read data relayed straight from the SRAM during the high phase
   assign LINK.dev_bus_out = SRAM_DQ_IN;
   assign LINK.dev_bus_oe  = is_read;

   assign PROGRAM_INDICATORS = prog_reg;
   assign PROGRAM_MODE       = prog_mode_reg;
   assign READ_LED           = is_read;
   assign WRITE_LED          = is_write;
   assign LATCH_LED          = is_load;

endmodule

// ===== hdl/bbsc_host.sv
// Host end: APB register slave that issues strobed commands on the link
`timescale 1ns/1ps
module bbsc_host (
   input  wire logic        CORE_CLK,
   input  wire logic        RESET,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   bbsc_link_if.host        LINK
);
   import bbsc_pkg::*;

   bbsc_state_type    state_reg;
   logic [3:0]        cnt_reg;
   logic [1:0]        sel_reg;
   logic [BYTE_W-1:0] wdata_reg;
   logic [BYTE_W-1:0] rdata_reg;
   logic              card_rst_reg;
   logic              strobe_reg;
   logic              oe_reg;
   logic [BYTE_W-1:0] bus_sync1_reg;
   logic [BYTE_W-1:0] bus_sync2_reg;
   logic [31:0]       prdata_reg;
   logic              pslverr_reg;
   logic              wr_access;
   logic              start;

   assign wr_access = PSEL && PENABLE && PWRITE;
   assign start = wr_access && (PADDR == REG_CMD_OFS) &&
                  (state_reg == ST_IDLE);

   // Read data prepared in the setup cycle, so no wait states
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (PSEL && !PENABLE) begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
         unique case (PADDR)
            REG_CMD_OFS: begin
               prdata_reg[CMD_SEL_LSB+:2]       <= sel_reg;
               prdata_reg[CMD_DATA_LSB+:BYTE_W] <= wdata_reg;
            end
            REG_STATUS_OFS: begin
               prdata_reg[STATUS_BUSY_BIT]  <= (state_reg != ST_IDLE);
               prdata_reg[STATUS_CARD_RST_BIT] <= card_rst_reg;
               prdata_reg[STATUS_RDATA_LSB+:BYTE_W] <= rdata_reg;
            end
            REG_CTRL_OFS: begin
               prdata_reg[CTRL_CARD_RST_BIT] <= card_rst_reg;
            end
            default: begin
               pslverr_reg <= 1'b1;
            end
         endcase
      end
   end

   assign PRDATA  = prdata_reg;
   assign PREADY  = 1'b1;
   assign PSLVERR = pslverr_reg;

   // Card held in reset until software releases it
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         card_rst_reg <= CTRL_CARD_RST_RESET;
      end else if (wr_access && (PADDR == REG_CTRL_OFS)) begin
         card_rst_reg <= PWDATA[CTRL_CARD_RST_BIT];
      end
   end

   // Command latch; a write while busy is dropped
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         sel_reg   <= CMD_WRITE;
         wdata_reg <= BYTE_RESET;
      end else if (start) begin
         sel_reg   <= PWDATA[CMD_SEL_LSB+:2];
         wdata_reg <= PWDATA[CMD_DATA_LSB+:BYTE_W];
      end
   end

   // Bus sampled through two flops, device answers on its own clock
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         bus_sync1_reg <= BYTE_RESET;
         bus_sync2_reg <= BYTE_RESET;
      end else begin
         bus_sync1_reg <= LINK.shared_byte_bus;
         bus_sync2_reg <= bus_sync1_reg;
      end
   end

   // Strobe sequencer: setup, high phase, low phase
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         state_reg  <= ST_IDLE;
         cnt_reg    <= 4'h0;
         strobe_reg <= 1'b0;
         oe_reg     <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               strobe_reg <= 1'b0;
               oe_reg     <= 1'b0;
               if (start) begin
                  state_reg <= ST_SETUP;
                  cnt_reg   <= SETUP_CYCLES;
                  oe_reg    <= (PWDATA[CMD_SEL_LSB+:2] != CMD_READ);
               end
            end
            ST_SETUP: begin
               if (cnt_reg == 4'h1) begin
                  state_reg  <= ST_HIGH;
                  cnt_reg    <= HIGH_CYCLES;
                  strobe_reg <= 1'b1;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            ST_HIGH: begin
               if (cnt_reg == 4'h1) begin
                  state_reg  <= ST_LOW;
                  cnt_reg    <= LOW_CYCLES;
                  strobe_reg <= 1'b0;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            ST_LOW: begin
               if (cnt_reg == 4'h1) begin
                  state_reg <= ST_IDLE;
                  cnt_reg   <= 4'h0;
                  oe_reg    <= 1'b0;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
         endcase
      end
   end

   // Read byte taken at the end of the high phase
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         rdata_reg <= BYTE_RESET;
      end else if (state_reg == ST_HIGH && cnt_reg == 4'h1 &&
                   sel_reg == CMD_READ) begin
         rdata_reg <= bus_sync2_reg;
      end
   end

   assign LINK.strobe          = strobe_reg;
   assign LINK.cmd_select_high = sel_reg[1];
   assign LINK.cmd_select_low  = sel_reg[0];
   assign LINK.card_reset_n    = !card_rst_reg;
   assign LINK.host_bus_out    = wdata_reg;
   assign LINK.host_bus_oe     = oe_reg;

endmodule

// ===== verification/bbsc_assertions.sv
// Concurrent checks on the host to controller link
`timescale 1ns/1ps
module bbsc_assertions (
   input wire logic                        CORE_CLK,
   input wire logic                        RESET,
   input wire logic                        strobe,
   input wire logic                        cmd_select_high,
   input wire logic                        cmd_select_low,
   input wire logic                        card_reset_n,
   input wire logic                        host_bus_oe,
   input wire logic [bbsc_pkg::ADDR_W-1:0] SRAM_ADDR,
   input wire logic                        SRAM_OE_N,
   input wire logic                        SRAM_WE_N,
   input wire logic                        SRAM_CE_N,
   input wire logic                        SRAM_DQ_OE,
   input wire logic [bbsc_pkg::PROG_W-1:0] PROGRAM_INDICATORS,
   input wire logic                        PROGRAM_MODE,
   input wire logic                        READ_LED,
   input wire logic                        WRITE_LED,
   input wire logic                        LATCH_LED
);
   import bbsc_pkg::*;
   logic [1:0] sel;
   logic       run;
   logic       live;
   assign sel = {cmd_select_high, cmd_select_low};
   assign run = strobe && !PROGRAM_MODE;
   assign live = card_reset_n;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   sequence s_pulse;
      strobe [*6] ##1 !strobe;
   endsequence
   a_pulse_shape: assert property ($rose(strobe) |-> s_pulse)
      else $error("strobe pulse length wrong");
   a_bus_dir: assert property (strobe |->
      host_bus_oe == (sel != CMD_READ))
      else $error("host bus direction wrong");
   a_oe_read: assert property (!SRAM_OE_N == (run && sel == CMD_READ))
      else $error("output enable wrong");
   a_we_write: assert property (!SRAM_WE_N == (run && sel == CMD_WRITE))
      else $error("write enable wrong");
   a_led_read: assert property (READ_LED == (run && sel == CMD_READ))
      else $error("read indicator wrong");
   a_led_write: assert property (WRITE_LED == (run && sel == CMD_WRITE))
      else $error("write indicator wrong");
   a_led_latch: assert property (LATCH_LED == (run && sel[1]))
      else $error("latch indicator wrong");
   // Address may only move at a strobe fall
   a_idle_still: assert property (!strobe && $past(!strobe) && live &&
      $past(live) |-> $stable(SRAM_ADDR)) else $error("address moved idle");
   a_top_bits: assert property ($changed(SRAM_ADDR[18:16]) && live &&
      $past(live) |-> $fell(strobe) && (!sel[1] || SRAM_ADDR[18:16] == 3'h0))
      else $error("top address bits changed wrongly");
   a_prog_once: assert property ($changed(PROGRAM_INDICATORS) && live &&
      $past(live) |-> $past(PROGRAM_MODE) && !PROGRAM_MODE)
      else $error("behaviour bits changed outside program mode");
   a_card_reset: assert property (!card_reset_n |-> PROGRAM_MODE &&
      SRAM_ADDR == ADDR_RESET) else $error("card reset state wrong");
   a_ce_select: assert property (!SRAM_CE_N ==
      (!SRAM_OE_N || !SRAM_WE_N)) else $error("chip select wrong");
   a_dq_drive: assert property (SRAM_DQ_OE == !SRAM_WE_N)
      else $error("data drive wrong");
   // Strobe fall that ends a low byte load in normal mode
   sequence s_low_load;
      live && $past(live) && $fell(strobe) && sel == CMD_LOAD_LOW &&
         !$past(PROGRAM_MODE);
   endsequence
   a_low_keep: assert property (s_low_load |->
      SRAM_ADDR[18:8] == $past(SRAM_ADDR[18:8]))
      else $error("low load moved upper address");
endmodule

// ===== verification/test_byte_bus_sram_controller.sv
// Self-checking bench: host and controller joined over the link
`timescale 1ns/1ps
module test_byte_bus_sram_controller;
   import bbsc_pkg::*;
   logic              CORE_CLK, PREADY, PSLVERR, PROGRAM_MODE, wr_pend = 1'b0;
   logic              RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic              SRAM_CE_N, SRAM_OE_N, SRAM_WE_N, SRAM_DQ_OE;
   logic              READ_LED, WRITE_LED, LATCH_LED;
   logic [11:0]       PADDR = 12'h000;
   logic [31:0]       PWDATA = 32'h0000_0000, PRDATA;
   logic [ADDR_W-1:0] SRAM_ADDR, waddr;
   logic [BYTE_W-1:0] SRAM_DQ_IN, SRAM_DQ_OUT;
   logic [PROG_W-1:0] PROGRAM_INDICATORS;
   logic [BYTE_W-1:0] mem [int], exp_mem [int];
   int                n_fail = 0, total_checks = 0;

   bbsc_link_if lnk ();
   bbsc_host i_bbsc_host (.CORE_CLK(CORE_CLK), .RESET(RESET), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .LINK(lnk));
   bbsc_device i_bbsc_device (.LINK(lnk), .SRAM_ADDR(SRAM_ADDR),
      .SRAM_DQ_IN(SRAM_DQ_IN), .SRAM_DQ_OUT(SRAM_DQ_OUT),
      .SRAM_DQ_OE(SRAM_DQ_OE),
      .SRAM_CE_N(SRAM_CE_N), .SRAM_OE_N(SRAM_OE_N), .SRAM_WE_N(SRAM_WE_N),
      .PROGRAM_INDICATORS(PROGRAM_INDICATORS), .PROGRAM_MODE(PROGRAM_MODE),
      .READ_LED(READ_LED), .WRITE_LED(WRITE_LED), .LATCH_LED(LATCH_LED));
   bbsc_assertions u_chk (.CORE_CLK(CORE_CLK), .RESET(RESET),
      .strobe(lnk.strobe), .cmd_select_high(lnk.cmd_select_high),
      .cmd_select_low(lnk.cmd_select_low), .card_reset_n(lnk.card_reset_n),
      .host_bus_oe(lnk.host_bus_oe), .SRAM_ADDR(SRAM_ADDR),
      .SRAM_OE_N(SRAM_OE_N), .SRAM_WE_N(SRAM_WE_N),
      .SRAM_CE_N(SRAM_CE_N), .SRAM_DQ_OE(SRAM_DQ_OE),
      .PROGRAM_INDICATORS(PROGRAM_INDICATORS), .PROGRAM_MODE(PROGRAM_MODE),
      .READ_LED(READ_LED), .WRITE_LED(WRITE_LED), .LATCH_LED(LATCH_LED));

   initial begin
      CORE_CLK = 1'b0;
      forever #4 CORE_CLK = ~CORE_CLK;
   end

   // Async SRAM; address taken as write enable falls, since it steps at rise
   always @(negedge SRAM_WE_N) begin
      waddr = SRAM_ADDR;
      wr_pend = 1'b1;
   end
   always @(posedge SRAM_WE_N) if (wr_pend) begin
      mem[int'(waddr)] = SRAM_DQ_OUT;
      wr_pend = 1'b0;
   end
   // Unselected data lines keep changing so stale bytes never match
   always @(SRAM_ADDR or SRAM_OE_N or SRAM_CE_N or CORE_CLK) begin
      if (!SRAM_OE_N && !SRAM_CE_N)
         SRAM_DQ_IN = mem.exists(int'(SRAM_ADDR)) ?
                      mem[int'(SRAM_ADDR)] : 8'h00;
      else
         SRAM_DQ_IN = SRAM_ADDR[7:0] ^ {8{CORE_CLK}};
   end

   function automatic logic [18:0] step(logic [18:0] a, logic sg, logic mg);
      return !mg ? a : sg ? a + 19'h1 : a - 19'h1;
   endfunction
   function automatic logic [7:0] exp_of(logic [18:0] a);
      return exp_mem.exists(int'(a)) ? exp_mem[int'(a)] : 8'h00;
   endfunction

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
      int n;
      @(posedge CORE_CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge CORE_CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 50);
      if (PREADY !== 1'b1) begin
         n_fail++;
         end_sim();
      end
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   // Issue one command, then poll until the strobe sequence has ended
   task automatic cmd(input logic [1:0] s, input logic [7:0] d,
                      output logic [31:0] r);
      logic e;
      int   n;
      apb(1'b1, REG_CMD_OFS, {22'h0, s, d}, r, e);
      n = 0;
      do begin
         apb(1'b0, REG_STATUS_OFS, 32'h0, r, e);
         n++;
      end while (r[STATUS_BUSY_BIT] !== 1'b0 && n < 40);
      if (r[STATUS_BUSY_BIT] !== 1'b0) begin
         n_fail++;
         end_sim();
      end
   endtask

   initial begin
      logic [31:0] r;
      logic        e;
      logic [18:0] ea, a0;
      logic [7:0]  m, l, d;
      logic [3:0]  p;
      void'($urandom(32'hA48C5B19));
      repeat (4) @(posedge CORE_CLK);
      RESET <= 1'b0;
      apb(1'b0, REG_CTRL_OFS, 32'h0, r, e);
      check("ctrl reset", r[CTRL_CARD_RST_BIT], CTRL_CARD_RST_RESET);
      apb(1'b1, 12'h00C, 32'hFFFF_FFFF, r, e);
      check("unmapped error", e, 1'b1);
      for (int t = 0; t < 6; t++) begin
         if (t == 3) begin
            // Host reset in mid-run puts the card back in reset too
            RESET <= 1'b1;
            repeat (2) @(posedge CORE_CLK);
            RESET <= 1'b0;
            apb(1'b0, REG_CTRL_OFS, 32'h0, r, e);
            check("ctrl", r[CTRL_CARD_RST_BIT], CTRL_CARD_RST_RESET);
         end
         p = (t == 0) ? 4'hF : (t == 1) ? 4'h5 : 4'($urandom);
         m = (t == 1) ? 8'h00 : 8'($urandom);
         l = (t == 1) ? 8'h00 : 8'($urandom);
         apb(1'b1, REG_CTRL_OFS, 32'h1, r, e);
         apb(1'b0, REG_STATUS_OFS, 32'h0, r, e);
         check("card rst status", r[STATUS_CARD_RST_BIT], 1'b1);
         check("card rst mode", PROGRAM_MODE, 1'b1);
         check("card rst addr", SRAM_ADDR, ADDR_RESET);
         apb(1'b1, REG_CTRL_OFS, 32'h0, r, e);
         // Program strobe under a load select must not load
         cmd(t[0] ? CMD_LOAD_LOW : CMD_WRITE, {4'($urandom), p}, r);
         check("behaviour bits", PROGRAM_INDICATORS, p);
         check("program mode", PROGRAM_MODE, 1'b0);
         check("addr at start", SRAM_ADDR, ADDR_RESET);
         cmd(CMD_LOAD_MID, m, r);
         cmd(CMD_LOAD_LOW, l, r);
         a0 = {3'h0, m, l};
         check("addr load", SRAM_ADDR, a0);
         ea = a0;
         repeat (4) begin
            d = 8'($urandom);
            exp_mem[int'(ea)] = d;
            cmd(CMD_WRITE, d, r);
            ea = step(ea, p[PROG_WRITE_SIGN_BIT], p[PROG_WRITE_MAG_BIT]);
            check("addr after write", SRAM_ADDR, ea);
         end
         d = 8'($urandom);
         cmd(CMD_LOAD_LOW, d, r);
         check("addr low only", SRAM_ADDR, {ea[18:8], d});
         check("behaviour kept", PROGRAM_INDICATORS, p);
         cmd(CMD_LOAD_MID, m, r);
         check("addr mid clear", SRAM_ADDR, {3'h0, m, d});
         // Second command lands while busy and must be dropped
         apb(1'b1, REG_CMD_OFS, {22'h0, CMD_LOAD_LOW, l}, r, e);
         cmd(CMD_LOAD_LOW, ~l, r);
         check("busy drop", SRAM_ADDR, a0);
         apb(1'b0, REG_CMD_OFS, 32'h0, r, e);
         check("cmd readback", r[9:0], {CMD_LOAD_LOW, l});
         ea = a0;
         repeat (4) begin
            cmd(CMD_READ, 8'h00, r);
            check("read data", r[STATUS_RDATA_LSB +: 8], exp_of(ea));
            ea = step(ea, p[PROG_READ_SIGN_BIT], p[PROG_READ_MAG_BIT]);
            check("addr after read", SRAM_ADDR, ea);
         end
         $display("test %0d done", t);
      end
      end_sim();
   end
endmodule
